// ==== hw/rtc_pin_ctrl.sv ====
module rtc_pin_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // time base and clock output
  input wire logic time_base_in,
  input wire logic clock_out_divide_select,
  output logic divided_clock_out,
  output logic square_wave_out,
  // host bus pins
  input wire logic chip_select_n,
  input wire logic address_strobe_in,
  input wire logic data_strobe_in,
  input wire logic read_write_in,
  input wire logic [7:0] muxed_addr_data_in,
  output logic [7:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe,
  // interrupt pin, open drain
  output logic irq_n_out,
  output logic irq_n_oe,
  // reset pin of the device
  input wire logic power_on_clear_n,
  // time keeping side
  input wire logic update_in_progress,
  input wire logic alarm_event,
  input wire logic update_done_event,
  input wire logic [7:0] ext_read_data,
  output logic ext_write_strobe,
  output logic [5:0] ext_write_addr,
  output logic [7:0] ext_write_data,
  // control bits for the time keeping side
  output logic set_update_inhibit,
  output logic binary_data_mode,
  output logic hour_24_mode,
  output logic daylight_save_enable
);
  tap_if tap ();

  tap_divider u_div (
    .clk(clk),
    .rst_b(rst_b),
    .time_base_in(time_base_in),
    .clock_out_divide_select(clock_out_divide_select),
    .tap(tap)
  );

  // bus group
  rtc_pkg::bus_state_t state, next_state;
  rtc_pkg::bus_mode_t mode, next_mode;
  logic as_prev, strobe_prev, rw_prev;
  logic next_as_prev, next_strobe_prev, next_rw_prev;
  logic [7:0] bus_prev, next_bus_prev;
  logic [5:0] addr, next_addr;
  logic [7:0] bus_out, next_bus_out;
  logic bus_oe, next_bus_oe;
  logic cs_act, as_fall, read_go, read_end, wr_go, c_read_done;
  logic [7:0] read_val;

  // register group
  logic [3:0] rate, next_rate;
  logic [2:0] base_sel, next_base_sel;
  logic [7:0] ctrl_b, next_ctrl_b;
  logic periodic_flag, alarm_flag, update_done_flag, any_int_flag;
  logic next_periodic_flag, next_alarm_flag;
  logic next_update_done_flag, next_any_int_flag;
  logic irq_oe_q, next_irq_oe;
  logic sq_out, next_sq_out;
  logic wr_strobe, next_wr_strobe;
  logic [5:0] wr_addr, next_wr_addr;
  logic [7:0] wr_data, next_wr_data;

  always_comb begin
    cs_act = ~chip_select_n;
    next_as_prev = address_strobe_in;
    next_strobe_prev = data_strobe_in;
    next_rw_prev = read_write_in;
    next_bus_prev = muxed_addr_data_in;
    as_fall = cs_act & as_prev & ~address_strobe_in;
    next_addr = addr;
    next_mode = mode;
    if (as_fall) begin
      next_addr = bus_prev[5:0];
      next_mode = strobe_prev ? rtc_pkg::MODE_PULSE
                          : rtc_pkg::MODE_STROBE;
    end
    // a read waits for the address strobe to drop, so the bus has turned
    read_go = 1'b0;
    read_end = 1'b0;
    wr_go = 1'b0;
    // decode with the style picked this cycle, so the old style cannot
    // start a read in the cycle the address strobe falls
    if (next_mode == rtc_pkg::MODE_STROBE) begin
      read_go = data_strobe_in & read_write_in;
      read_end = ~data_strobe_in;
      wr_go = strobe_prev & ~data_strobe_in & ~rw_prev;
    end else begin
      read_go = ~data_strobe_in;
      read_end = data_strobe_in;
      wr_go = ~rw_prev & read_write_in;
    end
    read_go = read_go & cs_act & ~address_strobe_in &
              (state == rtc_pkg::ST_IDLE);
    read_end = (read_end | ~cs_act) & (state == rtc_pkg::ST_READ);
    wr_go = wr_go & cs_act & ~address_strobe_in;
    unique case (addr)
      rtc_pkg::ADDR_CTRL_A: read_val = {update_in_progress, base_sel, rate};
      rtc_pkg::ADDR_CTRL_B: read_val = ctrl_b;
      rtc_pkg::ADDR_STAT_C: read_val = {any_int_flag, periodic_flag,
                                        alarm_flag, update_done_flag, 4'h0};
      default: read_val = ext_read_data;
    endcase
    next_state = state;
    next_bus_out = bus_out;
    if (read_go) begin
      next_state = rtc_pkg::ST_READ;
      next_bus_out = read_val;
    end else if (read_end) begin
      next_state = rtc_pkg::ST_IDLE;
    end
    next_bus_oe = (next_state == rtc_pkg::ST_READ) & cs_act;
    c_read_done = read_end & (addr == rtc_pkg::ADDR_STAT_C);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= rtc_pkg::ST_IDLE;
      mode <= rtc_pkg::MODE_STROBE;
      as_prev <= 1'b0;
      strobe_prev <= 1'b0;
      rw_prev <= 1'b1;
      bus_prev <= 8'h00;
      addr <= 6'h00;
      bus_out <= 8'h00;
      bus_oe <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      as_prev <= next_as_prev;
      strobe_prev <= next_strobe_prev;
      rw_prev <= next_rw_prev;
      bus_prev <= next_bus_prev;
      addr <= next_addr;
      bus_out <= next_bus_out;
      bus_oe <= next_bus_oe;
    end
  end

  always_comb begin
    next_rate = rate;
    next_base_sel = base_sel;
    next_ctrl_b = ctrl_b;
    if (wr_go && addr == rtc_pkg::ADDR_CTRL_A) begin
      next_rate = bus_prev[rtc_pkg::RATE_LSB +: 4];
      next_base_sel = bus_prev[rtc_pkg::BASE_LSB +: 3];
    end
    if (wr_go && addr == rtc_pkg::ADDR_CTRL_B) begin
      next_ctrl_b = bus_prev;
      if (bus_prev[rtc_pkg::SET_BIT]) begin
        next_ctrl_b[rtc_pkg::UPD_EN_BIT] = 1'b0;
      end
    end
    // only these control bits and the flags below answer the reset pin; time and memory stay intact
    if (!power_on_clear_n) begin
      next_ctrl_b[rtc_pkg::PER_EN_BIT] = 1'b0;
      next_ctrl_b[rtc_pkg::ALM_EN_BIT] = 1'b0;
      next_ctrl_b[rtc_pkg::UPD_EN_BIT] = 1'b0;
      next_ctrl_b[rtc_pkg::SQ_EN_BIT] = 1'b0;
    end
    next_periodic_flag = periodic_flag;
    next_alarm_flag = alarm_flag;
    next_update_done_flag = update_done_flag;
    if (c_read_done) begin
      next_periodic_flag = 1'b0;
      next_alarm_flag = 1'b0;
      next_update_done_flag = 1'b0;
    end
    // an event in the clearing cycle is kept
    if (tap.rise) begin
      next_periodic_flag = 1'b1;
    end
    if (alarm_event) begin
      next_alarm_flag = 1'b1;
    end
    if (update_done_event) begin
      next_update_done_flag = 1'b1;
    end
    if (!power_on_clear_n) begin
      next_periodic_flag = 1'b0;
      next_alarm_flag = 1'b0;
      next_update_done_flag = 1'b0;
    end
    next_any_int_flag =
      (next_periodic_flag & next_ctrl_b[rtc_pkg::PER_EN_BIT]) |
      (next_alarm_flag & next_ctrl_b[rtc_pkg::ALM_EN_BIT]) |
      (next_update_done_flag & next_ctrl_b[rtc_pkg::UPD_EN_BIT]);
    next_irq_oe = next_any_int_flag;
    next_sq_out = ctrl_b[rtc_pkg::SQ_EN_BIT] & tap.level;
    next_wr_strobe = wr_go && addr != rtc_pkg::ADDR_CTRL_A &&
                     addr != rtc_pkg::ADDR_CTRL_B &&
                     addr != rtc_pkg::ADDR_STAT_C;
    next_wr_addr = wr_go ? addr : wr_addr;
    next_wr_data = wr_go ? bus_prev : wr_data;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rate <= rtc_pkg::RATE_RESET;
      base_sel <= rtc_pkg::BASE_RESET;
      ctrl_b <= rtc_pkg::CTRL_B_RESET;
      periodic_flag <= 1'b0;
      alarm_flag <= 1'b0;
      update_done_flag <= 1'b0;
      any_int_flag <= 1'b0;
      irq_oe_q <= 1'b0;
      sq_out <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 8'h00;
    end else begin
      rate <= next_rate;
      base_sel <= next_base_sel;
      ctrl_b <= next_ctrl_b;
      periodic_flag <= next_periodic_flag;
      alarm_flag <= next_alarm_flag;
      update_done_flag <= next_update_done_flag;
      any_int_flag <= next_any_int_flag;
      irq_oe_q <= next_irq_oe;
      sq_out <= next_sq_out;
      wr_strobe <= next_wr_strobe;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  assign tap.rate = rate;
  assign tap.base_sel = base_sel;
  assign divided_clock_out = tap.clk_out;
  assign square_wave_out = sq_out;
  assign muxed_addr_data_out = bus_out;
  assign muxed_addr_data_oe = bus_oe;
  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_oe_q;
  assign ext_write_strobe = wr_strobe;
  assign ext_write_addr = wr_addr;
  assign ext_write_data = wr_data;
  assign set_update_inhibit = ctrl_b[rtc_pkg::SET_BIT];
  assign binary_data_mode = ctrl_b[rtc_pkg::DM_BIT];
  assign hour_24_mode = ctrl_b[rtc_pkg::H24_BIT];
  assign daylight_save_enable = ctrl_b[rtc_pkg::DSE_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_cs_float: assert property (chip_select_n |=> !muxed_addr_data_oe)
    else $error("bus driven while deselected");
  chk_addr_latch: assert property (as_fall |=> addr == $past(bus_prev[5:0]))
    else $error("address not latched at strobe fall");
  chk_mode_pick: assert property (as_fall && !strobe_prev |=>
    mode == rtc_pkg::MODE_STROBE)
    else $error("bus style not taken from strobe level");
  chk_read_float: assert property (read_end |=> !muxed_addr_data_oe)
    else $error("bus still driven after read end");
  chk_irq_level: assert property (irq_n_oe ==
    ((periodic_flag && ctrl_b[6]) || (alarm_flag && ctrl_b[5]) ||
    (update_done_flag && ctrl_b[4])))
    else $error("interrupt line does not follow flags");
  chk_clear_pin: assert property (!power_on_clear_n |=>
    !periodic_flag && !alarm_flag && !update_done_flag && !any_int_flag &&
    !irq_n_oe)
    else $error("flags survive reset pin");
  chk_enable_clear: assert property (!power_on_clear_n |=>
    ctrl_b[6:3] == 4'h0)
    else $error("enables survive reset pin");
  chk_sqw_low: assert property (!ctrl_b[3] |=> !square_wave_out)
    else $error("square wave not held low");
  chk_periodic_rate: assert property (tap.rise && power_on_clear_n |=>
    periodic_flag)
    else $error("periodic flag missed");
  chk_c_read: assert property (c_read_done && !tap.rise && !alarm_event &&
    !update_done_event |=> !irq_n_oe ##1 !muxed_addr_data_oe)
    else $error("status read did not release line");

  cov_strobe_read: cover property (mode == rtc_pkg::MODE_STROBE && read_go);
  cov_pulse_write: cover property (mode == rtc_pkg::MODE_PULSE && wr_go);
  cov_irq_on: cover property (!irq_n_oe ##1 irq_n_oe);
  cov_status_read: cover property (c_read_done && any_int_flag);
endmodule

// ==== hw/rtc_pkg.sv ====
package rtc_pkg;
  localparam logic [5:0] ADDR_CTRL_A = 6'h0A;
  localparam logic [5:0] ADDR_CTRL_B = 6'h0B;
  localparam logic [5:0] ADDR_STAT_C = 6'h0C;
  localparam int CHAIN_STAGES = 22;
  localparam int RATE_LSB = 0;
  localparam int BASE_LSB = 4;
  localparam int UIP_BIT = 7;
  localparam int SET_BIT = 7;
  localparam int PER_EN_BIT = 6;
  localparam int ALM_EN_BIT = 5;
  localparam int UPD_EN_BIT = 4;
  localparam int SQ_EN_BIT = 3;
  localparam int DM_BIT = 2;
  localparam int H24_BIT = 1;
  localparam int DSE_BIT = 0;
  localparam int SUM_FLAG_BIT = 7;
  localparam int PER_FLAG_BIT = 6;
  localparam int ALM_FLAG_BIT = 5;
  localparam int UPD_FLAG_BIT = 4;
  localparam logic [2:0] BASE_4M = 3'h0;
  localparam logic [2:0] BASE_1M = 3'h1;
  localparam logic [2:0] BASE_32K = 3'h2;
  localparam logic [1:0] BASE_HOLD = 2'h3;
  localparam logic [4:0] PRESCALE_4M = 5'h07;
  localparam logic [4:0] PRESCALE_1M = 5'h05;
  localparam logic [4:0] PRESCALE_32K = 5'h00;
  localparam logic [4:0] SLOW_LOW_RATE_OFS = 5'h05;
  localparam logic [4:0] FAST_RATE_OFS = 5'h02;
  localparam logic [3:0] RATE_OFF = 4'h0;
  localparam logic [3:0] RATE_SLOW_LAST_SPECIAL = 4'h2;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [2:0] BASE_RESET = 3'h0;
  typedef enum logic {MODE_STROBE, MODE_PULSE} bus_mode_t;
  typedef enum logic {ST_IDLE, ST_READ} bus_state_t;
endpackage

// ==== hw/tap_if.sv ====
interface tap_if;
  logic [3:0] rate;
  logic [2:0] base_sel;
  logic level;
  logic rise;
  logic clk_out;
  modport ctrl (output rate, output base_sel, input level, input rise,
    input clk_out);
  modport chain (input rate, input base_sel, output level, output rise,
    output clk_out);
endinterface

// ==== hw/tap_divider.sv ====
module tap_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // time base pins
  input wire logic time_base_in,
  input wire logic clock_out_divide_select,
  // tap selection and results
  tap_if.chain tap
);
  logic tb_prev;
  logic [rtc_pkg::CHAIN_STAGES-1:0] chain;
  logic [1:0] quarter;
  logic level_prev;
  logic clk_out_q;
  logic next_tb_prev;
  logic [rtc_pkg::CHAIN_STAGES-1:0] next_chain;
  logic [1:0] next_quarter;
  logic next_level_prev;
  logic next_clk_out;
  logic tb_rise;
  logic level_now;
  logic rise_prev;
  logic next_rise_prev;

  // fast bases add prescale stages so every base lands on the same taps for rates 3 and up
  function automatic logic [4:0] tap_index(input logic [3:0] rs,
                                           input logic [2:0] base);
    logic [4:0] pre;
    pre = rtc_pkg::PRESCALE_32K;
    if (base == rtc_pkg::BASE_4M) begin
      pre = rtc_pkg::PRESCALE_4M;
    end else if (base == rtc_pkg::BASE_1M) begin
      pre = rtc_pkg::PRESCALE_1M;
    end
    if (pre == rtc_pkg::PRESCALE_32K &&
        rs <= rtc_pkg::RATE_SLOW_LAST_SPECIAL) begin
      tap_index = {1'b0, rs} + rtc_pkg::SLOW_LOW_RATE_OFS;
    end else begin
      tap_index = pre + {1'b0, rs} - rtc_pkg::FAST_RATE_OFS;
    end
  endfunction

  always_comb begin
    tb_rise = time_base_in & ~tb_prev;
    next_tb_prev = time_base_in;
    next_chain = chain;
    next_quarter = quarter;
    if (tb_rise) begin
      next_quarter = quarter + 2'h1;
    end
    // divider is held clear while the base field asks for it
    if (tap.base_sel[2:1] == rtc_pkg::BASE_HOLD) begin
      next_chain = '0;
    end else if (tb_rise) begin
      next_chain = chain + 22'h000001;
    end
    level_now = 1'b0;
    if (tap.rate != rtc_pkg::RATE_OFF) begin
      level_now = chain[tap_index(tap.rate, tap.base_sel)];
    end
    next_level_prev = level_now;
    next_rise_prev = level_prev;
    next_clk_out = clock_out_divide_select ? time_base_in
                                           : quarter[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tb_prev <= 1'b0;
      chain <= '0;
      quarter <= 2'h0;
      level_prev <= 1'b0;
      clk_out_q <= 1'b0;
      rise_prev <= 1'b0;
    end else begin
      tb_prev <= next_tb_prev;
      chain <= next_chain;
      quarter <= next_quarter;
      level_prev <= next_level_prev;
      clk_out_q <= next_clk_out;
      rise_prev <= next_rise_prev;
    end
  end

  assign tap.level = level_prev;
  assign tap.rise = level_prev & ~rise_prev;
  assign tap.clk_out = clk_out_q;
endmodule

// ==== verification/host_bus_model.sv ====
module host_bus_model (
  // clock
  input wire logic clk,
  // pins toward the device
  output logic chip_select_n,
  output logic address_strobe_in,
  output logic data_strobe_in,
  output logic read_write_in,
  output logic [7:0] muxed_addr_data_in,
  // device drive of the bus
  input wire logic [7:0] muxed_addr_data_out,
  input wire logic muxed_addr_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_oe;
  logic [7:0] host_d;
  logic [7:0] last_v;
  // no pull resistor: a released bus shows a pattern that moves every cycle
  always_comb begin
    if (muxed_addr_data_oe)
      muxed_addr_data_in = muxed_addr_data_out;
    else if (host_oe)
      muxed_addr_data_in = host_d;
    else
      muxed_addr_data_in = ~last_v;
  end
  always @(posedge clk) last_v <= muxed_addr_data_in;
  initial begin
    chip_select_n = 1'b1;
    address_strobe_in = 1'b0;
    data_strobe_in = 1'b0;
    read_write_in = 1'b1;
    host_oe = 1'b0;
    host_d = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // every pin level is held at least two cycles so the device sees each edge
  task automatic xfer(input bit p, input bit w, input bit s,
    input logic [5:0] a, input logic [7:0] wd, output logic [7:0] rd,
    output logic oe);
    // style level is set while deselected, select comes with the address
    @(negedge clk);
    data_strobe_in = p;
    read_write_in = 1'b1;
    step(2);
    chip_select_n = ~s;
    address_strobe_in = 1'b1;
    host_oe = 1'b1;
    host_d = {2'h3, a};
    step(2);
    address_strobe_in = 1'b0;
    step(2);
    rd = 8'h00;
    oe = 1'b0;
    if (w) begin
      // pulse style keeps its read pulse idle high during a write
      host_d = wd;
      read_write_in = 1'b0;
      data_strobe_in = 1'b1;
      step(2);
      read_write_in = p ? 1'b1 : 1'b0;
      data_strobe_in = p;
      step(2);
    end else begin
      host_oe = 1'b0;
      data_strobe_in = ~p;
      step(3);
      rd = muxed_addr_data_out;
      oe = muxed_addr_data_oe;
      data_strobe_in = p;
      step(2);
    end
    host_oe = 1'b0;
    chip_select_n = 1'b1;
    read_write_in = 1'b1;
    data_strobe_in = 1'b0;
    step(2);
  endtask
endmodule

// ==== verification/rtc_mux_bus_and_pin_control_tb_top.sv ====
module rtc_mux_bus_and_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, time_base_in, clock_out_divide_select, power_on_clear_n;
  logic update_in_progress, alarm_event, update_done_event;
  logic [7:0] ext_read_data, muxed_addr_data_in, muxed_addr_data_out;
  logic [7:0] ext_write_data, rd;
  logic divided_clock_out, square_wave_out, chip_select_n, address_strobe_in;
  logic data_strobe_in, read_write_in, muxed_addr_data_oe, irq_n_out, irq_n_oe;
  logic ext_write_strobe, set_update_inhibit, binary_data_mode, oe;
  logic hour_24_mode, daylight_save_enable;
  logic [5:0] ext_write_addr;
  int bad_count, comparisons, ext_pulses, tb_cnt;

  rtc_pin_ctrl dut_u (.clk(clk), .rst_b(rst_b), .time_base_in(time_base_in),
    .clock_out_divide_select(clock_out_divide_select),
    .divided_clock_out(divided_clock_out), .square_wave_out(square_wave_out),
    .chip_select_n(chip_select_n), .address_strobe_in(address_strobe_in),
    .data_strobe_in(data_strobe_in), .read_write_in(read_write_in),
    .muxed_addr_data_in(muxed_addr_data_in),
    .muxed_addr_data_out(muxed_addr_data_out),
    .muxed_addr_data_oe(muxed_addr_data_oe), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .power_on_clear_n(power_on_clear_n),
    .update_in_progress(update_in_progress), .alarm_event(alarm_event),
    .update_done_event(update_done_event), .ext_read_data(ext_read_data),
    .ext_write_strobe(ext_write_strobe), .ext_write_addr(ext_write_addr),
    .ext_write_data(ext_write_data), .set_update_inhibit(set_update_inhibit),
    .binary_data_mode(binary_data_mode), .hour_24_mode(hour_24_mode),
    .daylight_save_enable(daylight_save_enable));
  host_bus_model host_u (.clk(clk), .chip_select_n(chip_select_n),
    .address_strobe_in(address_strobe_in), .data_strobe_in(data_strobe_in),
    .read_write_in(read_write_in), .muxed_addr_data_in(muxed_addr_data_in),
    .muxed_addr_data_out(muxed_addr_data_out),
    .muxed_addr_data_oe(muxed_addr_data_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // time base of eight clocks per period, far below the sampling rate
  always @(negedge clk) begin
    tb_cnt <= tb_cnt + 1;
    time_base_in <= tb_cnt[2];
  end
  always @(posedge clk) if (ext_write_strobe === 1'b1) ext_pulses++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
    input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input bit p, input bit w, input bit s,
    input logic [5:0] a, input logic [7:0] d);
    host_u.xfer(p, w, s, a, d, rd, oe);
  endtask
  task automatic wait_irq(input logic e);
    int i;
    i = 0;
    while (irq_n_oe !== e && i < 20) begin
      @(negedge clk);
      i++;
    end
    check({7'h00, irq_n_oe}, {7'h00, e}, "irq line");
  endtask
  task automatic rises(input int n, input bit dv, output int c);
    logic prv, cur;
    c = 0;
    prv = dv ? divided_clock_out : square_wave_out;
    repeat (n) begin
      @(negedge clk);
      cur = dv ? divided_clock_out : square_wave_out;
      if (cur === 1'b1 && prv === 1'b0) c++;
      prv = cur;
    end
  endtask
  task automatic pulse_event(input bit upd);
    @(negedge clk);
    if (upd) update_done_event = 1'b1;
    else alarm_event = 1'b1;
    @(negedge clk);
    update_done_event = 1'b0;
    alarm_event = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic t_strobe();
    bus(0, 1, 1, 6'h0B, 8'h87);
    check({4'h0, set_update_inhibit, binary_data_mode, hour_24_mode,
      daylight_save_enable}, 8'h0F, "ctrl b levels");
    bus(0, 0, 1, 6'h0B, 8'h00);
    check(rd, 8'h87, "ctrl b read");
    check({7'h00, oe}, 8'h01, "read drive");
    check({7'h00, muxed_addr_data_oe}, 8'h00, "float after");
    bus(0, 1, 1, 6'h0B, 8'h00);
    $display("test strobe_regs done");
  endtask
  task automatic t_pulse();
    update_in_progress = 1'b1;
    bus(1, 1, 1, 6'h0A, 8'h20);
    bus(1, 0, 1, 6'h0A, 8'h00);
    check(rd, 8'hA0, "ctrl a pulse read");
    bus(0, 0, 1, 6'h0A, 8'h00);
    check(rd, 8'hA0, "ctrl a strobe read");
    $display("test pulse_regs done");
  endtask
  task automatic t_ext();
    bus(1, 1, 1, 6'h15, 8'h5A);
    check(ext_pulses[7:0], 8'h01, "ext strobe");
    check({2'h0, ext_write_addr}, 8'h15, "ext addr");
    check(ext_write_data, 8'h5A, "ext data");
    bus(0, 1, 0, 6'h16, 8'hA5);
    check(ext_pulses[7:0], 8'h01, "deselected write");
    bus(0, 0, 0, 6'h15, 8'h00);
    check({7'h00, oe}, 8'h00, "deselected read");
    bus(0, 1, 1, 6'h17, 8'hC3);
    check(ext_write_data, 8'hC3, "strobe write data");
    bus(0, 0, 1, 6'h15, 8'h00);
    check(rd, 8'h3C, "ext read");
    $display("test ext_access done");
  endtask
  task automatic t_irq();
    bus(0, 1, 1, 6'h0B, 8'h20);
    pulse_event(1'b0);
    wait_irq(1'b1);
    check({7'h00, irq_n_out}, 8'h00, "irq low");
    bus(0, 0, 1, 6'h0C, 8'h00);
    check(rd, 8'hA0, "status alarm");
    wait_irq(1'b0);
    bus(0, 1, 1, 6'h0B, 8'h10);
    pulse_event(1'b1);
    wait_irq(1'b1);
    bus(1, 0, 1, 6'h0C, 8'h00);
    check(rd, 8'h90, "status update");
    wait_irq(1'b0);
    bus(0, 1, 1, 6'h0B, 8'h00);
    pulse_event(1'b0);
    repeat (4) @(negedge clk);
    check({7'h00, irq_n_oe}, 8'h00, "masked alarm");
    bus(0, 0, 1, 6'h0C, 8'h00);
    check(rd, 8'h20, "masked flag");
    $display("test interrupts done");
  endtask
  task automatic t_periodic();
    int c;
    bus(0, 1, 1, 6'h0A, 8'h23);
    rises(300, 1'b0, c);
    check(c[7:0], 8'h00, "square held low");
    bus(0, 0, 1, 6'h0C, 8'h00);
    check(rd & 8'hC0, 8'h40, "periodic flag");
    bus(0, 1, 1, 6'h0B, 8'h08);
    rises(300, 1'b0, c);
    check({7'h00, c >= 3}, 8'h01, "square runs");
    bus(0, 1, 1, 6'h0B, 8'h48);
    wait_irq(1'b1);
    $display("test periodic done");
  endtask
  task automatic t_divided_clock_out();
    int c;
    rises(128, 1'b1, c);
    check({7'h00, c >= 15 && c <= 17}, 8'h01, "divided_clock_out full");
    clock_out_divide_select = 1'b0;
    repeat (16) @(negedge clk);
    rises(128, 1'b1, c);
    check({7'h00, c >= 3 && c <= 5}, 8'h01, "divided_clock_out quarter");
    $display("test clock_out done");
  endtask
  task automatic t_reset_pin();
    int c;
    bus(0, 1, 1, 6'h0B, 8'h7E);
    pulse_event(1'b0);
    wait_irq(1'b1);
    power_on_clear_n = 1'b0;
    repeat (3) @(negedge clk);
    check({7'h00, irq_n_oe}, 8'h00, "pin floats");
    power_on_clear_n = 1'b1;
    rises(100, 1'b0, c);
    check(c[7:0], 8'h00, "square off");
    bus(0, 0, 1, 6'h0B, 8'h00);
    check(rd, 8'h06, "ctrl b cleared");
    bus(0, 0, 1, 6'h0C, 8'h00);
    check(rd & 8'hB0, 8'h00, "flags cleared");
    bus(0, 0, 1, 6'h0A, 8'h00);
    check(rd, 8'hA3, "ctrl a kept");
    $display("test reset_pin done");
  endtask

  initial begin
    bad_count = 0;
    comparisons = 0;
    ext_pulses = 0;
    tb_cnt = 0;
    rst_b = 1'b0;
    time_base_in = 1'b0;
    clock_out_divide_select = 1'b1;
    power_on_clear_n = 1'b1;
    update_in_progress = 1'b0;
    alarm_event = 1'b0;
    update_done_event = 1'b0;
    ext_read_data = 8'h3C;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_strobe();
    t_pulse();
    t_ext();
    t_irq();
    t_periodic();
    t_divided_clock_out();
    t_reset_pin();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
